// *** spimsb_pkg.sv ***
package spimsb_pkg;
  // Register offsets
  localparam logic [2:0] ADDR_CONTROL_A  = 3'h0;
  localparam logic [2:0] ADDR_CONTROL_B  = 3'h1;
  localparam logic [2:0] ADDR_IRQ_EN     = 3'h2;
  localparam logic [2:0] ADDR_IRQ_FLAGS  = 3'h3;
  localparam logic [2:0] ADDR_SHIFT_DATA = 3'h4;
  // Control A fields
  localparam int CA_ENABLE_BIT   = 0;
  localparam int CA_SCK_PRESCALER_LSB    = 1;
  localparam int CA_DOUBLE_BIT   = 4;
  localparam int CA_MASTER_BIT   = 5;
  localparam int CA_ORDER_BIT    = 6;
  localparam logic [7:0] CA_RESET = 8'h00;
  localparam logic [7:0] CA_MASK  = 8'h77;
  // Control B fields
  localparam int CB_MODE_LSB     = 0;
  localparam int CB_SSD_BIT      = 2;
  localparam int CB_BUFFER_WAIT_FOR_RECEIVE_BIT    = 6;
  localparam int CB_BUFFER_MODE_ENABLE_BIT    = 7;
  localparam logic [7:0] CB_RESET = 8'h00;
  localparam logic [7:0] CB_MASK  = 8'hc7;
  // Interrupt enable / flag fields
  localparam int IRQ_RXC_BIT     = 7;
  localparam int IRQ_TXC_BIT     = 6;
  localparam int IRQ_DRE_BIT     = 5;
  localparam int IRQ_SSI_BIT     = 4;
  localparam int IRQ_BYTE_BIT    = 0;
  localparam logic [7:0] IE_RESET = 8'h00;
  localparam logic [7:0] IE_MASK  = 8'hf1;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // Prescaler half periods in peripheral clocks (divide by 4,16,64,128)
  localparam logic [6:0] HALF_DIVIDE_BY_FOUR   = 7'd2;
  localparam logic [6:0] HALF_DIV16  = 7'd8;
  localparam logic [6:0] HALF_DIV64  = 7'd32;
  localparam logic [6:0] HALF_DIVIDE_BY_128 = 7'd64;
  typedef enum logic [1:0] {SPIMSB_IDLE, SPIMSB_LEAD, SPIMSB_TRAIL, SPIMSB_DONE} spimsb_state_t;
endpackage

// *** spimsb_core.sv ***
`timescale 1ns/1ps
module spimsb_core
  import spimsb_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_sys_rst,
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  output logic            o_irq,
  input  wire logic       i_idle_sleep,
  input  wire logic       i_deep_sleep,
  input  wire logic       i_ss_is_output,
  input  wire logic       i_ss_n,
  input  wire logic       i_sck,
  input  wire logic       i_mosi,
  input  wire logic       i_miso,
  output logic            o_sck,
  output logic            o_sck_oe,
  output logic            o_mosi,
  output logic            o_mosi_oe,
  output logic            o_miso,
  output logic            o_miso_oe
);
  logic [7:0] control_a;
  logic [7:0] control_b;
  logic [7:0] interrupt_enables;
  logic       receive_complete_flag;  // Also the byte-done flag when unbuffered
  logic       transfer_complete_flag;
  logic       write_collision_flag;
  logic       tx_buffer_empty_flag;
  logic       select_trigger_flag;
  logic       rx_overflow_flag;
  logic [7:0] shift_reg;
  logic [7:0] tx_buf;
  logic       tx_full;
  logic [7:0] rx_fifo [2];
  logic [1:0] rx_count;
  logic [2:0] bit_cnt;
  logic [6:0] div_cnt;
  logic       sck_q;
  logic       in_bit;
  logic       dre_rise_q;
  logic       rxc_rise_q;
  logic       all_sent_q;
  logic       flags_read_armed;
  logic       preload_pend;
  logic [7:0] preload_data;
  logic       ss_q;
  spimsb_state_t state;

  logic       enabled, master, bit_order, clock_double, buffer_mode_enable, buffer_wait_for_receive, slave_select_disable;
  logic [1:0] sck_prescaler, mode;
  logic       cpol, cpha;
  logic       wr_data, rd_data, wr_flags, rd_flags;
  logic       busy, done, abort, ss_drop, lead_edge, trail_edge, rx_bit;
  logic       slave_lead, slave_trail, sck_slave;
  logic [6:0] half_period;
  logic [7:0] rx_byte;

  assign enabled   = control_a[CA_ENABLE_BIT];
  assign master    = control_a[CA_MASTER_BIT];
  assign bit_order = control_a[CA_ORDER_BIT];
  assign clock_double     = control_a[CA_DOUBLE_BIT];
  assign sck_prescaler     = control_a[CA_SCK_PRESCALER_LSB +: 2];
  assign buffer_mode_enable     = control_b[CB_BUFFER_MODE_ENABLE_BIT];
  assign buffer_wait_for_receive     = control_b[CB_BUFFER_WAIT_FOR_RECEIVE_BIT];
  assign slave_select_disable       = control_b[CB_SSD_BIT];
  assign mode      = control_b[CB_MODE_LSB +: 2];
  assign cpol      = mode[1];
  assign cpha      = mode[0];
  assign wr_data   = i_wr && (i_addr == ADDR_SHIFT_DATA);
  assign rd_data   = i_rd && (i_addr == ADDR_SHIFT_DATA);
  assign wr_flags  = i_wr && (i_addr == ADDR_IRQ_FLAGS);
  assign rd_flags  = i_rd && (i_addr == ADDR_IRQ_FLAGS);
  assign busy      = (state != SPIMSB_IDLE);
  assign abort     = i_deep_sleep && !i_idle_sleep;
  // Master dropped by a low select input unless select is disabled or the select pin is an output
  assign ss_drop   = master && enabled && !i_ss_is_output && !i_ss_n && !slave_select_disable;

  // Prescaler half period select; double halves it in master only
  function automatic logic [6:0] half_of(input logic [1:0] p, input logic dbl);
    logic [6:0] h;
    h = HALF_DIVIDE_BY_FOUR;
    case (p)
      2'd0: h = HALF_DIVIDE_BY_FOUR;
      2'd1: h = HALF_DIV16;
      2'd2: h = HALF_DIV64;
      default: h = HALF_DIVIDE_BY_128;
    endcase
    if (dbl) begin
      h = h >> 1;
    end
    return h;
  endfunction
  assign half_period = half_of(sck_prescaler, clock_double);

  // Slave SCK edges seen relative to polarity; inputs are synchronous
  assign sck_slave   = i_sck ^ cpol;
  assign slave_lead  = !master && sck_slave && !sck_q;
  assign slave_trail = !master && !sck_slave && sck_q;
  assign lead_edge   = master ? (div_cnt == 7'd0 && state == SPIMSB_LEAD) : slave_lead;
  assign trail_edge  = master ? (div_cnt == 7'd0 && state == SPIMSB_TRAIL) : slave_trail;
  assign done        = trail_edge && (bit_cnt == 3'd7);
  // Trailing-edge sampling closes the byte on the same edge, so the last bit comes straight from the pin
  assign rx_bit      = cpha ? (master ? i_miso : i_mosi) : in_bit;
  assign rx_byte     = bit_order ? {rx_bit, shift_reg[7:1]} : {shift_reg[6:0], rx_bit};

  function automatic logic out_bit(input logic [7:0] s, input logic lsb);
    return lsb ? s[0] : s[7];
  endfunction

  // Control registers; hardware clears master on a select fault
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      control_a         <= CA_RESET;
      control_b         <= CB_RESET;
      interrupt_enables <= IE_RESET;
    end else begin
      if (i_wr && i_addr == ADDR_CONTROL_A) begin
        control_a <= i_wdata & CA_MASK;
      end else if (ss_drop) begin
        control_a[CA_MASTER_BIT] <= 1'b0;
      end
      if (i_wr && i_addr == ADDR_CONTROL_B) begin
        control_b <= i_wdata & CB_MASK;
      end
      if (i_wr && i_addr == ADDR_IRQ_EN) begin
        interrupt_enables <= i_wdata & IE_MASK;
      end
    end
  end

  // Transfer engine: master generates SCK, slave follows external SCK
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      state   <= SPIMSB_IDLE;
      bit_cnt <= 3'd0;
      div_cnt <= 7'd0;
      sck_q   <= 1'b0;
      in_bit  <= 1'b0;
      ss_q    <= 1'b1;
    end else begin
      sck_q <= sck_slave;
      ss_q  <= i_ss_n;
      if (abort || !enabled || ss_drop || (!master && i_ss_n)) begin
        state   <= SPIMSB_IDLE;
        bit_cnt <= 3'd0;
        div_cnt <= 7'd0;
      end else begin
        case (state)
          SPIMSB_IDLE: begin
            if (master && wr_data && !buffer_mode_enable) begin
              state   <= SPIMSB_LEAD;
              div_cnt <= half_period - 7'd1;
            end else if (master && buffer_mode_enable && (tx_full || wr_data)) begin
              state   <= SPIMSB_LEAD;
              div_cnt <= half_period - 7'd1;
            end else if (!master && !i_ss_n) begin
              state <= SPIMSB_LEAD;
            end
          end
          SPIMSB_LEAD: begin
            if (master) begin
              div_cnt <= (div_cnt == 7'd0) ? half_period - 7'd1 : div_cnt - 7'd1;
            end
            if (lead_edge) begin
              state <= SPIMSB_TRAIL;
            end
          end
          SPIMSB_TRAIL: begin
            if (master) begin
              div_cnt <= (div_cnt == 7'd0) ? half_period - 7'd1 : div_cnt - 7'd1;
            end
            if (trail_edge) begin
              bit_cnt <= bit_cnt + 3'd1;
              state   <= (bit_cnt == 3'd7) ? SPIMSB_DONE : SPIMSB_LEAD;
            end
          end
          default: begin
            state <= SPIMSB_IDLE;
          end
        endcase
      end
      // Sample on the leading edge in modes 0/2, trailing in 1/3
      if ((lead_edge && !cpha) || (trail_edge && cpha)) begin
        in_bit <= master ? i_miso : i_mosi;
      end
    end
  end

  // Shift register; setup on the edge opposite the sample edge
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      shift_reg    <= DATA_RESET;
      preload_pend <= 1'b0;
      preload_data <= DATA_RESET;
    end else begin
      preload_pend <= 1'b0;
      if (buffer_mode_enable && buffer_wait_for_receive && !master && i_ss_n && wr_data && !preload_pend && !tx_full && !busy) begin
        preload_pend <= 1'b1;
        preload_data <= i_wdata;
      end
      if (preload_pend) begin
        shift_reg <= preload_data;
      end else if (done && buffer_mode_enable && tx_full) begin
        shift_reg <= tx_buf;
      end else if (done) begin
        shift_reg <= rx_byte;
      end else if (wr_data && !buffer_mode_enable && !busy) begin
        shift_reg <= i_wdata;
      end else if (((trail_edge && !cpha) || (lead_edge && cpha && bit_cnt != 3'd0)) && state != SPIMSB_IDLE) begin
        shift_reg <= bit_order ? {in_bit, shift_reg[7:1]} : {shift_reg[6:0], in_bit};
      end
    end
  end

  // Transmit buffer
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      tx_buf  <= DATA_RESET;
      tx_full <= 1'b0;
    end else if (!buffer_mode_enable) begin
      tx_full <= 1'b0;
    end else if (done && tx_full) begin
      tx_full <= 1'b0;
    end else if (wr_data && !tx_full && !(buffer_wait_for_receive && !master && i_ss_n && !busy && !preload_pend)) begin
      tx_buf  <= i_wdata;
      tx_full <= 1'b1;
    end
  end

  // Receive FIFO, two entries, oldest at index 0
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      rx_fifo[0] <= DATA_RESET;
      rx_fifo[1] <= DATA_RESET;
      rx_count   <= 2'd0;
    end else begin
      if (done) begin
        if (!buffer_mode_enable) begin
          rx_fifo[0] <= rx_byte;
          rx_count   <= 2'd1;
        end else if (rd_data && rx_count != 2'd0) begin
          rx_fifo[0] <= (rx_count == 2'd2) ? rx_fifo[1] : rx_byte;
          rx_fifo[1] <= rx_byte;
        end else if (rx_count != 2'd2) begin
          rx_fifo[rx_count[0]] <= rx_byte;
          rx_count <= rx_count + 2'd1;
        end
      end else if (rd_data && buffer_mode_enable && rx_count != 2'd0) begin
        rx_fifo[0] <= rx_fifo[1];
        rx_count   <= rx_count - 2'd1;
      end
    end
  end

  // Flags: hardware set wins over software clear
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      receive_complete_flag  <= 1'b0;
      transfer_complete_flag <= 1'b0;
      write_collision_flag   <= 1'b0;
      tx_buffer_empty_flag   <= 1'b0;
      select_trigger_flag    <= 1'b0;
      rx_overflow_flag       <= 1'b0;
      dre_rise_q             <= 1'b0;
      rxc_rise_q             <= 1'b0;
      all_sent_q             <= 1'b0;
      flags_read_armed       <= 1'b0;
    end else begin
      dre_rise_q <= done && buffer_mode_enable && tx_full;
      rxc_rise_q <= all_sent_q;
      all_sent_q <= done && buffer_mode_enable && !tx_full;
      if (rd_flags) begin
        flags_read_armed <= 1'b1;
      end else if (rd_data || wr_data) begin
        flags_read_armed <= 1'b0;
      end
      if (buffer_mode_enable) begin
        if (done && tx_full) begin
          tx_buffer_empty_flag <= 1'b1;
        end else if (wr_data && !tx_full) begin
          tx_buffer_empty_flag <= 1'b0;
        end
        if (dre_rise_q || all_sent_q) begin
          receive_complete_flag <= 1'b1;
        end else if ((wr_flags && i_wdata[IRQ_RXC_BIT]) || (rd_data && rx_count == 2'd1)) begin
          receive_complete_flag <= 1'b0;
        end
        if (rxc_rise_q && !tx_full) begin
          transfer_complete_flag <= 1'b1;
        end else if (wr_flags && i_wdata[IRQ_TXC_BIT]) begin
          transfer_complete_flag <= 1'b0;
        end
        if (!master && ss_q && !i_ss_n) begin
          select_trigger_flag <= 1'b1;
        end else if (wr_flags && i_wdata[IRQ_SSI_BIT]) begin
          select_trigger_flag <= 1'b0;
        end
        if (done && rx_count == 2'd2 && !rd_data) begin
          rx_overflow_flag <= 1'b1;
        end else if (wr_flags && i_wdata[IRQ_BYTE_BIT]) begin
          rx_overflow_flag <= 1'b0;
        end
      end else begin
        tx_buffer_empty_flag <= 1'b0;
        if (done || ss_drop) begin
          receive_complete_flag <= 1'b1;
        end else if (flags_read_armed && (rd_data || wr_data)) begin
          receive_complete_flag <= 1'b0;
        end
        if (wr_data && busy) begin
          write_collision_flag <= 1'b1;
        end else if (flags_read_armed && (rd_data || wr_data)) begin
          write_collision_flag <= 1'b0;
        end
      end
    end
  end

  // Single combined request
  always_comb begin
    if (buffer_mode_enable) begin
      o_irq = (receive_complete_flag && interrupt_enables[IRQ_RXC_BIT]) ||
              (transfer_complete_flag && interrupt_enables[IRQ_TXC_BIT]) ||
              (tx_buffer_empty_flag && interrupt_enables[IRQ_DRE_BIT]) ||
              (select_trigger_flag && interrupt_enables[IRQ_SSI_BIT]);
    end else begin
      o_irq = receive_complete_flag && interrupt_enables[IRQ_BYTE_BIT];
    end
  end

  // Register read, one cycle latency, no side effects beyond flags/data
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      if (i_addr == ADDR_CONTROL_A) begin
        o_rdata <= control_a;
      end else if (i_addr == ADDR_CONTROL_B) begin
        o_rdata <= control_b;
      end else if (i_addr == ADDR_IRQ_EN) begin
        o_rdata <= interrupt_enables;
      end else if (i_addr == ADDR_IRQ_FLAGS) begin
        o_rdata <= {receive_complete_flag, buffer_mode_enable ? transfer_complete_flag : write_collision_flag,
                    tx_buffer_empty_flag, select_trigger_flag, 3'h0, rx_overflow_flag};
      end else if (i_addr == ADDR_SHIFT_DATA) begin
        o_rdata <= rx_fifo[0];
      end else begin
        o_rdata <= 8'h00;
      end
    end
  end

  // Pins: master drives SCK and MOSI, selected slave drives MISO
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_sck <= 1'b0;
    end else if (master && state == SPIMSB_TRAIL) begin
      o_sck <= !cpol;
    end else begin
      o_sck <= cpol;  // idle level
    end
  end
  assign o_sck_oe  = enabled && master;
  assign o_mosi    = out_bit(shift_reg, bit_order);
  assign o_mosi_oe = enabled && master;
  assign o_miso    = out_bit(shift_reg, bit_order);
  assign o_miso_oe = enabled && !master && !i_ss_n;
endmodule

// *** spimsb_core_chk.sv ***
`timescale 1ns/1ps
module spimsb_core_chk
  import spimsb_pkg::*;
(
  input wire logic       i_mclk,
  input wire logic       i_sys_rst,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       o_irq,
  input wire logic       i_idle_sleep,
  input wire logic       i_deep_sleep,
  input wire logic       i_ss_n,
  input wire logic       o_sck,
  input wire logic       o_sck_oe,
  input wire logic       o_mosi_oe,
  input wire logic       o_miso_oe
);
  logic [7:0] ca_sw;
  logic [7:0] ie_sw;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  // Software copy: hardware may drop the master bit but never raise enable or master
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      ca_sw <= 8'h00;
      ie_sw <= 8'h00;
    end else if (i_wr && i_addr == ADDR_CONTROL_A) begin
      ca_sw <= i_wdata;
    end else if (i_wr && i_addr == ADDR_IRQ_EN) begin
      ie_sw <= i_wdata & IE_MASK;
    end
  end
  property p_sel_oe;
    o_miso_oe |-> !i_ss_n;
  endproperty
  a_sel_oe: assert property (p_sel_oe) else $error("slave output on while deselected");
  property p_oe_excl;
    !(o_mosi_oe && o_miso_oe);
  endproperty
  a_oe_excl: assert property (p_oe_excl) else $error("master and slave drive together");
  property p_sck_oe;
    o_sck_oe |-> ca_sw[CA_ENABLE_BIT] && ca_sw[CA_MASTER_BIT] && o_mosi_oe;
  endproperty
  a_sck_oe: assert property (p_sck_oe) else $error("clock driven outside master mode");
  property p_unmapped;
    i_rd && i_addr > ADDR_SHIFT_DATA |=> o_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_hold;
    !i_rd |=> $stable(o_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  property p_deep;
    (i_deep_sleep && !i_idle_sleep) [*4] |-> $stable(o_sck);
  endproperty
  a_deep: assert property (p_deep) else $error("clock runs in deep sleep");
  property p_irq_off;
    i_wr && i_addr == ADDR_IRQ_EN && i_wdata == 8'h00 |=> !o_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("request stays with all enables off");
  property p_irq_en;
    o_irq |-> ie_sw != 8'h00;
  endproperty
  a_irq_en: assert property (p_irq_en) else $error("request without any enable");
  c_sck: cover property (o_sck_oe && $changed(o_sck));
  c_slave: cover property (o_miso_oe);
  c_irq: cover property (o_irq);
endmodule

bind spimsb_core spimsb_core_chk u_spimsb_core_chk (
  .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .i_idle_sleep(i_idle_sleep),
  .i_deep_sleep(i_deep_sleep), .i_ss_n(i_ss_n), .o_sck(o_sck), .o_sck_oe(o_sck_oe),
  .o_mosi_oe(o_mosi_oe), .o_miso_oe(o_miso_oe)
);

// *** spimsb_far_end.sv ***
`timescale 1ns/1ps
module spimsb_far_end #(
  parameter int HALF = 6
) (
  input  wire logic       i_mclk,
  input  wire logic       i_go,
  input  wire logic [1:0] i_mode,
  input  wire logic [7:0] i_tx,
  input  wire logic [3:0] i_bits,
  input  wire logic       i_miso,
  output logic            o_sck,
  output logic            o_mosi,
  output logic            o_ss_n,
  output logic            o_busy,
  output logic [7:0]      o_rx
);
  logic [7:0] sh;
  logic [7:0] rx;
  // External master; clock parked between frames, fewer than 8 bits means an abort
  initial begin
    o_sck = 1'b0;
    o_mosi = 1'b1;
    o_ss_n = 1'b1;
    o_busy = 1'b0;
    o_rx = 8'h00;
    forever begin
      @(posedge i_mclk);
      o_sck <= i_mode[1];
      if (i_go) begin
        o_busy <= 1'b1;
        o_ss_n <= 1'b0;
        sh = i_tx;
        rx = 8'h00;
        o_mosi <= sh[7];
        repeat (HALF) @(posedge i_mclk);
        for (int b = 0; b < i_bits; b++) begin
          o_sck <= ~i_mode[1];
          if (i_mode[0])
            o_mosi <= sh[7];
          else
            rx = {rx[6:0], i_miso};
          repeat (HALF) @(posedge i_mclk);
          o_sck <= i_mode[1];
          if (i_mode[0])
            rx = {rx[6:0], i_miso};
          sh = {sh[6:0], ~sh[0]};
          if (!i_mode[0])
            o_mosi <= sh[7];
          repeat (HALF) @(posedge i_mclk);
        end
        o_ss_n <= 1'b1;
        o_mosi <= ~o_mosi; // Released line must not keep the last bit
        o_rx <= rx;
        o_busy <= 1'b0;
      end
    end
  end
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
  import spimsb_pkg::*;
  logic       i_mclk, i_sys_rst, i_wr, i_rd, i_idle_sleep, i_deep_sleep, pull_low, go, miso_w, ss_out;
  logic [2:0] i_addr;
  logic [7:0] i_wdata, o_rdata, far_tx, far_rx, got;
  logic [1:0] far_mode;
  logic [3:0] far_bits;
  logic       o_irq, o_sck, o_sck_oe, o_mosi, o_mosi_oe, o_miso, o_miso_oe;
  logic       far_sck, far_mosi, far_ss_n, far_busy;
  logic [7:0] smp [160];
  logic [7:0] rst_v [3] = '{CA_RESET, CB_RESET, IE_RESET};
  logic [7:0] msk [3] = '{CA_MASK, CB_MASK, IE_MASK};
  logic [6:0] hv [4] = '{HALF_DIVIDE_BY_FOUR, HALF_DIV16, HALF_DIV64, HALF_DIVIDE_BY_128};
  int         n_errors, comparisons, rises, t;
  // Master mode loops its own output back so received data is known
  assign miso_w = o_miso_oe ? o_miso : o_mosi;
  always #4 i_mclk = ~i_mclk;
  spimsb_core u_spimsb_core (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .i_idle_sleep(i_idle_sleep),
    .i_deep_sleep(i_deep_sleep), .i_ss_is_output(ss_out), .i_ss_n(far_ss_n & ~pull_low), .i_sck(far_sck),
    .i_mosi(far_mosi), .i_miso(miso_w), .o_sck(o_sck), .o_sck_oe(o_sck_oe), .o_mosi(o_mosi),
    .o_mosi_oe(o_mosi_oe), .o_miso(o_miso), .o_miso_oe(o_miso_oe));
  spimsb_far_end u_spimsb_far_end (.i_mclk(i_mclk), .i_go(go), .i_mode(far_mode), .i_tx(far_tx),
    .i_bits(far_bits), .i_miso(o_miso), .o_sck(far_sck), .o_mosi(far_mosi), .o_ss_n(far_ss_n),
    .o_busy(far_busy), .o_rx(far_rx));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Strobes rise after an edge and drop after the edge that takes them
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    @(posedge i_mclk);  // Lets an edge pass so a following write never reassigns the strobe
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(posedge i_mclk);
    d = o_rdata;
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  task automatic xfer(input logic [7:0] tx, input logic [3:0] nb, input logic ck, input logic [7:0] e);
    far_tx <= tx;
    far_bits <= nb;
    go <= 1'b1;
    @(posedge i_mclk);
    go <= 1'b0;
    repeat (2) @(posedge i_mclk);
    for (int j = 0; j < 400 && far_busy; j++) @(posedge i_mclk);
    repeat (4) @(posedge i_mclk);
    if (ck)
      chk(far_rx, e);
  endtask
  // Back-to-back flag reads, one sample per cycle
  task automatic poll();
    i_rd <= 1'b1;
    i_addr <= ADDR_IRQ_FLAGS;
    for (int j = 0; j < 160; j++) begin
      @(posedge i_mclk);
      smp[j] = o_rdata;
    end
    i_rd <= 1'b0;
  endtask
  task automatic mstr(input logic [1:0] p, input logic dbl);
    wr(ADDR_CONTROL_A, {3'b001, dbl, 1'b0, p, 1'b1});
    wr(ADDR_SHIFT_DATA, 8'ha5);
    for (t = 0; t < 300 && o_sck !== 1'b1; t++) @(posedge i_mclk);
    for (t = 0; t < 300 && o_sck !== 1'b0; t++) @(posedge i_mclk);
    chk(8'(t), {1'b0, hv[p] >> dbl});
    got = 8'h00;
    for (t = 0; t < 3000 && got[7] !== 1'b1; t++) rd(ADDR_IRQ_FLAGS, got);
    rdc(ADDR_SHIFT_DATA, 8'ha5);
  endtask
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge i_mclk);
    n_errors++;
    give_verdict();
  end
  initial begin
    {i_mclk, i_wr, i_rd, i_idle_sleep, i_deep_sleep, pull_low, go, ss_out} = 8'h00;
    {i_sys_rst, i_addr, i_wdata, far_tx, far_bits, far_mode} = {1'b1, 25'h0};
    n_errors = 0;
    comparisons = 0;
    repeat (10) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    // Reset values, writable bits, unmapped space
    rdc(ADDR_IRQ_FLAGS, 8'h00);
    rdc(ADDR_SHIFT_DATA, DATA_RESET);
    for (int a = 0; a < 3; a++) begin
      rdc(a[2:0], rst_v[a]);
      wr(a[2:0], 8'hff);
      rdc(a[2:0], msk[a]);
      wr(a[2:0], 8'h00);
    end
    for (int a = 5; a < 8; a++) rdc(a[2:0], 8'h00);
    // Buffered, first byte a dummy, third write lost
    wr(ADDR_CONTROL_B, 8'h80);
    wr(ADDR_CONTROL_A, 8'h01);
    wr(ADDR_SHIFT_DATA, 8'h43);
    rd(ADDR_IRQ_FLAGS, got);
    chk({7'h00, got[5]}, 8'h00);
    xfer(8'ha1, 4'd8, 1'b1, 8'h00);
    rdc(ADDR_SHIFT_DATA, 8'ha1);
    wr(ADDR_SHIFT_DATA, 8'h44);
    wr(ADDR_SHIFT_DATA, 8'h45);
    fork
      xfer(8'hb2, 4'd8, 1'b1, 8'h43);
      poll();
    join
    rises = 0;
    for (int j = 1; j < 159; j++) begin
      if (smp[j-1][5] === 1'b0 && smp[j][5] === 1'b1) begin
        rises++;
        chk({6'h00, smp[j][7], smp[j+1][7]}, 8'h01);
      end
    end
    chk(8'(rises), 8'h01);
    xfer(8'hc3, 4'd8, 1'b1, 8'h44);
    rd(ADDR_IRQ_FLAGS, got);
    chk({7'h00, got[6]}, 8'h01);
    rdc(ADDR_SHIFT_DATA, 8'hb2);
    rdc(ADDR_SHIFT_DATA, 8'hc3);
    wr(ADDR_CONTROL_B, 8'hc0);
    wr(ADDR_SHIFT_DATA, 8'h5a);
    xfer(8'hd4, 4'd8, 1'b1, 8'h5a);
    rdc(ADDR_SHIFT_DATA, 8'hd4);
    wr(ADDR_IRQ_FLAGS, 8'hff);
    // Unbuffered: every clock mode in both bit orders, with the byte interrupt
    wr(ADDR_IRQ_EN, 8'h01);
    for (int m = 0; m < 8; m++) begin
      far_mode <= m[1:0];
      wr(ADDR_CONTROL_B, {6'h00, m[1:0]});
      wr(ADDR_CONTROL_A, {1'b0, m[2], 5'h00, 1'b1});
      wr(ADDR_SHIFT_DATA, 8'h1d);
      xfer(8'h35, 4'd8, 1'b1, m[2] ? 8'hb8 : 8'h1d);
      chk({7'h00, o_irq}, 8'h01);
      rd(ADDR_IRQ_FLAGS, got);
      rdc(ADDR_SHIFT_DATA, m[2] ? 8'hac : 8'h35);
      chk({7'h00, o_irq}, 8'h00);
    end
    wr(ADDR_IRQ_EN, 8'h00);
    far_mode <= 2'h0;
    wr(ADDR_CONTROL_B, 8'h00);
    wr(ADDR_CONTROL_A, 8'h01);
    wr(ADDR_SHIFT_DATA, 8'h11);
    fork
      xfer(8'h22, 4'd8, 1'b1, 8'h11);
      begin
        repeat (40) @(posedge i_mclk);
        wr(ADDR_SHIFT_DATA, 8'h99);
      end
    join
    rd(ADDR_IRQ_FLAGS, got);
    chk({7'h00, got[6]}, 8'h01);
    rdc(ADDR_SHIFT_DATA, 8'h22);
    // Deselect in mid-byte drops the partial byte
    xfer(8'h5c, 4'd4, 1'b0, 8'h00);
    rd(ADDR_IRQ_FLAGS, got);
    chk({7'h00, got[7]}, 8'h00);
    xfer(8'h6e, 4'd8, 1'b0, 8'h00);
    rdc(ADDR_SHIFT_DATA, 8'h6e);
    // Master rates, kept running through idle sleep
    i_idle_sleep <= 1'b1;
    for (int m = 0; m < 8; m++) mstr(m[1:0], m[2]);
    i_idle_sleep <= 1'b0;
    wr(ADDR_CONTROL_A, 8'h21);
    pull_low <= 1'b1;
    repeat (4) @(posedge i_mclk);
    pull_low <= 1'b0;
    rdc(ADDR_CONTROL_A, 8'h01);
    rd(ADDR_IRQ_FLAGS, got);
    chk({7'h00, got[7]}, 8'h01);
    rd(ADDR_SHIFT_DATA, got);
    // Select pin as an output, or select disabled, never drops master operation
    ss_out <= 1'b1;
    wr(ADDR_CONTROL_A, 8'h21);
    pull_low <= 1'b1;
    repeat (4) @(posedge i_mclk);
    pull_low <= 1'b0;
    rdc(ADDR_CONTROL_A, 8'h21);
    ss_out <= 1'b0;
    wr(ADDR_CONTROL_B, 8'h04);
    wr(ADDR_CONTROL_A, 8'h21);
    pull_low <= 1'b1;
    repeat (4) @(posedge i_mclk);
    pull_low <= 1'b0;
    rdc(ADDR_CONTROL_A, 8'h21);
    // Deeper sleep cuts a slow master byte short
    wr(ADDR_CONTROL_A, 8'h27);
    wr(ADDR_SHIFT_DATA, 8'ha5);
    repeat (100) @(posedge i_mclk);
    i_deep_sleep <= 1'b1;
    repeat (10) @(posedge i_mclk);
    i_deep_sleep <= 1'b0;
    repeat (1200) @(posedge i_mclk);
    rd(ADDR_IRQ_FLAGS, got);
    chk({7'h00, got[7]}, 8'h00);
    give_verdict();
  end
endmodule
